// ==== rtl/lgcb_defines.svh ====
`ifndef LGCB_DEFINES_SVH
`define LGCB_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register addresses on the microprocessor port.
`define LGCB_GCR0_ADDR 16'h0fe0
`define LGCB_GCR1_ADDR 16'h0fe2

////////////////////////////////////////////////////////////////////////////////
// Reset values and writable masks. Bit 2 of the first register is unused and reads zero.
`define LGCB_GCR0_RESET 8'h00
`define LGCB_GCR1_RESET 8'h00
`define LGCB_GCR0_MASK 8'hfb
`define LGCB_GCR1_MASK 8'hff

////////////////////////////////////////////////////////////////////////////////
// Field positions in the first control register.
`define LGCB_SRST_BIT 0
`define LGCB_GIE_BIT 1
`define LGCB_POL_BIT 3
`define LGCB_TXEDGE_BIT 4
`define LGCB_RXEDGE_BIT 5

// Field positions in the second control register.
`define LGCB_GAUGE_LO 4
`define LGCB_GAUGE_HI 5

////////////////////////////////////////////////////////////////////////////////
// Timing. The hold time of the soft reset bit is a least time, so it rounds up.
`define LGCB_SYS_CLK_NS 25
`define LGCB_SRST_TIME_NS 10000
`define LGCB_SRST_CYC ((`LGCB_SRST_TIME_NS + `LGCB_SYS_CLK_NS - 1) / `LGCB_SYS_CLK_NS)

`endif

// ==== rtl/lgcb_link.sv ====
`timescale 1ns/1ps

// Logic on the line clock: transmit capture and receive launch.
module lgcb_link (
    input wire logic line_clk,
    input wire logic link_rst_req,
    input wire logic tx_edge_sel,
    input wire logic rx_edge_sel,
    input wire logic pol_sel,
    input wire lgcb_pkg::lgcb_rail_t rx_data_in,
    input wire lgcb_pkg::lgcb_rail_t tx_dual_rail_data,
    output lgcb_pkg::lgcb_rail_t tx_sample_q,
    output lgcb_pkg::lgcb_rail_t rx_dual_rail_data
);

    // Synchronised copies of everything arriving from the system clock, then the capture and launch flops and their inputs.
    logic link_rst;
    logic tx_edge_s;
    logic rx_edge_s;
    logic pol_s;
    lgcb_pkg::lgcb_rail_t rx_s;
    lgcb_pkg::lgcb_rail_t tx_pos_q, tx_neg_q, rx_pos_q, rx_neg_q;
    lgcb_pkg::lgcb_rail_t tx_sample_d, rx_pos_d;

    // Configuration, soft reset and receive data all pass two flip-flops.
    lgcb_sync #(.W(6)) u_sync (
        .clk(line_clk),
        .ce(1'b1),
        .d({link_rst_req, tx_edge_sel, rx_edge_sel, pol_sel, rx_data_in}),
        .q({link_rst, tx_edge_s, rx_edge_s, pol_s, rx_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pick the capture edge and fold in polarity; receive data launches inverted
    // when active low is selected.
    always_comb begin
        tx_sample_d = (tx_edge_s ? tx_pos_q : tx_neg_q) ^ {2{pol_s}};
        rx_pos_d = rx_s ^ {2{pol_s}};
        if (link_rst) begin
            tx_sample_d = 2'h0;
            rx_pos_d = 2'h0;
        end
    end

    // Rising-edge flops: raw capture, selected sample and rising launch.
    always_ff @(posedge line_clk) begin
        tx_pos_q <= tx_dual_rail_data;
        tx_sample_q <= tx_sample_d;
        rx_pos_q <= rx_pos_d;
    end

    // Falling-edge flops: raw capture and falling launch.
    always_ff @(negedge line_clk) begin
        tx_neg_q <= tx_dual_rail_data;
        rx_neg_q <= rx_pos_d;
    end

    // The launch edge chooses which flop drives the pins; the mux is the price
    // of serving both edges from one set of pins.
    assign rx_dual_rail_data = rx_edge_s ? rx_neg_q : rx_pos_q;

    ////////////////////////////////////////////////////////////////////////////
    // Rising capture: the sample equals the pin two edges earlier, polarity applied.
    property p_tx_rise;
        @(posedge line_clk) disable iff (link_rst)
        tx_edge_s && $past(tx_edge_s) |=>
            tx_sample_q == ($past(tx_dual_rail_data, 2) ^ {2{$past(pol_s)}});
    endproperty
    a_tx_rise: assert property (p_tx_rise) else $error("tx rising capture wrong");

    // Falling capture takes the value held by the falling-edge flop.
    property p_tx_fall;
        @(posedge line_clk) disable iff (link_rst)
        !tx_edge_s |=> tx_sample_q == ($past(tx_neg_q) ^ {2{$past(pol_s)}});
    endproperty
    a_tx_fall: assert property (p_tx_fall) else $error("tx falling capture wrong");

    // Receive pins follow the polarity-corrected source on the rising edge.
    property p_rx_rise;
        @(posedge line_clk) disable iff (link_rst)
        !rx_edge_s && !$past(rx_edge_s) && !$past(link_rst) |->
            rx_dual_rail_data == ($past(rx_s) ^ {2{$past(pol_s)}});
    endproperty
    a_rx_rise: assert property (p_rx_rise) else $error("rx rising launch wrong");

    c_tx_edge_change: cover property (@(posedge line_clk) $changed(tx_edge_s));

endmodule

// ==== rtl/lgcb_pkg.sv ====
package lgcb_pkg;

    // Progress of the software reset request.
    typedef enum logic [1:0] {
        SR_IDLE,
        SR_COUNT,
        SR_ACTIVE
    } lgcb_srst_state_t;

    // One dual-rail symbol: positive rail in bit 1, negative rail in bit 0.
    typedef logic [1:0] lgcb_rail_t;

    // Address decode shared by the write and the read path.
    function automatic logic lgcb_hit(input logic [15:0] addr, input logic [15:0] base);
        return addr == base;
    endfunction

endpackage

// ==== rtl/lgcb_sync.sv ====
`timescale 1ns/1ps

// Two-stage synchroniser for a bundle of slow levels.
module lgcb_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // First stage; only the second stage reads it.
    logic [W-1:0] meta_q;

    // Both stages move together so a frozen clock enable cannot split them.
    always_ff @(posedge clk) begin
        if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

// ==== rtl/lgcb_top.sv ====
`timescale 1ns/1ps
`include "lgcb_defines.svh"

module lgcb_top #(
    parameter int NSRC = 8,
    parameter int unsigned SRST_CYC = `LGCB_SRST_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [15:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata_q,
    input wire logic [NSRC-1:0] src_status,
    input wire logic [NSRC-1:0] src_enable,
    output logic irq_q,
    output logic dev_reset_q,
    output logic [1:0] gauge_select_q,
    output lgcb_pkg::lgcb_rail_t tx_data_q,
    input wire lgcb_pkg::lgcb_rail_t rx_data_in,
    input wire logic tx_line_clock,
    input wire lgcb_pkg::lgcb_rail_t tx_dual_rail_data,
    output lgcb_pkg::lgcb_rail_t rx_dual_rail_data
);

    // Counter width covers the full hold count.
    localparam int CW = $clog2(SRST_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    // The two global control registers.
    logic [7:0] gcr0_q, gcr0_d;
    logic [7:0] gcr1_q, gcr1_d;
    // Read data for the host.
    logic [7:0] host_rdata_d;
    // Decoded selects, shared by both register paths.
    logic sel0, sel1;

    // Soft reset sequencing.
    lgcb_pkg::lgcb_srst_state_t srst_q, srst_d;
    logic [CW-1:0] hold_cnt_q, hold_cnt_d;
    logic dev_reset_d;
    // Request to reset the line-clock logic, a level crossing to that domain.
    logic link_rst_req_q, link_rst_req_d;

    // Interrupt and data paths.
    logic irq_d;
    // Any source that is both pending and enabled; read by the gate and by two checks.
    logic src_any;
    logic [1:0] gauge_select_d;
    lgcb_pkg::lgcb_rail_t tx_data_d;
    // Transmit sample from the line domain, unsynchronised and synchronised.
    lgcb_pkg::lgcb_rail_t tx_sample_link;
    lgcb_pkg::lgcb_rail_t tx_sample_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.
    assign sel0 = lgcb_pkg::lgcb_hit(host_addr, `LGCB_GCR0_ADDR);
    assign sel1 = lgcb_pkg::lgcb_hit(host_addr, `LGCB_GCR1_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // Source merge. The sources are same-clock logic, so no synchroniser is needed.
    assign src_any = |(src_status & src_enable);

    ////////////////////////////////////////////////////////////////////////////
    // Register file. Writes store through a mask so the unused bit stays zero.
    // A read in the same cycle as a write returns the old contents.
    always_comb begin
        gcr0_d = gcr0_q;
        gcr1_d = gcr1_q;
        host_rdata_d = host_rdata_q;
        if (host_wr && sel0) begin
            gcr0_d = host_wdata & `LGCB_GCR0_MASK;
        end
        if (host_wr && sel1) begin
            gcr1_d = host_wdata & `LGCB_GCR1_MASK;
        end
        if (host_rd) begin
            // Unmapped addresses read as zero.
            host_rdata_d = sel0 ? gcr0_q : (sel1 ? gcr1_q : 8'h00);
        end
    end

    // The register file ignores the soft reset, so only the pin reset clears it.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gcr0_q <= `LGCB_GCR0_RESET;
            gcr1_q <= `LGCB_GCR1_RESET;
            host_rdata_q <= 8'h00;
        end else if (ce) begin
            gcr0_q <= gcr0_d;
            gcr1_q <= gcr1_d;
            host_rdata_q <= host_rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Soft reset: the bit must stay set for more than the hold count before the
    // device reset begins. A short glitch on the bit therefore does nothing.
    always_comb begin
        srst_d = srst_q;
        hold_cnt_d = hold_cnt_q;
        case (srst_q)
            lgcb_pkg::SR_IDLE: begin
                if (gcr0_q[`LGCB_SRST_BIT]) begin
                    srst_d = lgcb_pkg::SR_COUNT;
                    hold_cnt_d = '0;
                end
            end
            lgcb_pkg::SR_COUNT: begin
                if (!gcr0_q[`LGCB_SRST_BIT]) begin
                    // Released early: abandon the request.
                    srst_d = lgcb_pkg::SR_IDLE;
                end else if (hold_cnt_q == CW'(SRST_CYC)) begin
                    srst_d = lgcb_pkg::SR_ACTIVE;
                end else begin
                    hold_cnt_d = hold_cnt_q + CW'(1);
                end
            end
            lgcb_pkg::SR_ACTIVE: begin
                // Reset lasts until the host clears the bit again.
                if (!gcr0_q[`LGCB_SRST_BIT]) begin
                    srst_d = lgcb_pkg::SR_IDLE;
                end
            end
            default: begin
                srst_d = lgcb_pkg::SR_IDLE;
            end
        endcase
        dev_reset_d = srst_d == lgcb_pkg::SR_ACTIVE;
        link_rst_req_d = dev_reset_d;
    end

    // Sequencer state; the line logic is held in reset during pin reset too.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            srst_q <= lgcb_pkg::SR_IDLE;
            hold_cnt_q <= '0;
            dev_reset_q <= 1'b0;
            link_rst_req_q <= 1'b1;
        end else if (ce) begin
            srst_q <= srst_d;
            hold_cnt_q <= hold_cnt_d;
            dev_reset_q <= dev_reset_d;
            link_rst_req_q <= link_rst_req_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt, gauge and transmit data. The gate uses the next register value
    // so the pin drops in the same cycle that the gate bit reads zero.
    always_comb begin
        irq_d = gcr0_d[`LGCB_GIE_BIT] && src_any;
        gauge_select_d = gcr1_d[`LGCB_GAUGE_HI:`LGCB_GAUGE_LO];
        tx_data_d = tx_sample_sync;
        if (dev_reset_d) begin
            irq_d = 1'b0;
            tx_data_d = 2'h0;
        end
    end

    // Output flops.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
            gauge_select_q <= 2'h0;
            tx_data_q <= 2'h0;
        end else if (ce) begin
            irq_q <= irq_d;
            gauge_select_q <= gauge_select_d;
            tx_data_q <= tx_data_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossing of the transmit sample into the system domain. Each rail is a
    // level; a symbol that lasts under two system cycles may be missed.
    lgcb_sync #(.W(2)) u_tx_sync (
        .clk(sys_clk),
        .ce(ce),
        .d(tx_sample_link),
        .q(tx_sample_sync)
    );

    // Line-clock logic; configuration bits leave straight from their flops.
    lgcb_link u_link (
        .line_clk(tx_line_clock),
        .link_rst_req(link_rst_req_q),
        .tx_edge_sel(gcr0_q[`LGCB_TXEDGE_BIT]),
        .rx_edge_sel(gcr0_q[`LGCB_RXEDGE_BIT]),
        .pol_sel(gcr0_q[`LGCB_POL_BIT]),
        .rx_data_in(rx_data_in),
        .tx_dual_rail_data(tx_dual_rail_data),
        .tx_sample_q(tx_sample_link),
        .rx_dual_rail_data(rx_dual_rail_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the system clock.

    // Gate low means no interrupt, whatever the sources do.
    property p_gate_off;
        @(posedge sys_clk) disable iff (rst)
        !gcr0_q[`LGCB_GIE_BIT] |-> !irq_q;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("irq with gate off");

    // An interrupt needs an enabled, active source one cycle earlier.
    property p_src_needed;
        @(posedge sys_clk) disable iff (rst)
        $past(ce) && irq_q |-> gcr0_q[`LGCB_GIE_BIT] && $past(src_any);
    endproperty
    a_src_needed: assert property (p_src_needed) else $error("irq without source");

    // An enabled source with the gate open raises the pin next cycle.
    property p_src_raises;
        @(posedge sys_clk) disable iff (rst)
        ce && !dev_reset_d && gcr0_d[`LGCB_GIE_BIT] && (|(src_status & src_enable))
            |=> irq_q;
    endproperty
    a_src_raises: assert property (p_src_raises) else $error("irq missed");

    // Writing the gate to zero drops the pin on the next edge.
    property p_gate_clear;
        @(posedge sys_clk) disable iff (rst)
        ce && host_wr && sel0 && !host_wdata[`LGCB_GIE_BIT] |=> !irq_q;
    endproperty
    a_gate_clear: assert property (p_gate_clear) else $error("irq after gate clear");

    // The device reset starts only after the full hold and keeps the second register.
    property p_srst_hold;
        @(posedge sys_clk) disable iff (rst)
        $rose(dev_reset_q) |-> $past(hold_cnt_q) == CW'(SRST_CYC)
            && $past(gcr0_q[`LGCB_SRST_BIT]) && gcr1_q == $past(gcr1_d);
    endproperty
    a_srst_hold: assert property (p_srst_hold) else $error("soft reset early");

    // During the device reset the line logic, the interrupt and the transmit data are held clear.
    property p_srst_clear;
        @(posedge sys_clk) disable iff (rst)
        dev_reset_q |-> link_rst_req_q && !irq_q && tx_data_q == 2'h0;
    endproperty
    a_srst_clear: assert property (p_srst_clear) else $error("circuits not reset");

    // The gauge selector starts at zero after reset.
    property p_gauge_reset;
        @(posedge sys_clk)
        rst |=> gauge_select_q == 2'h0 && gcr1_q == `LGCB_GCR1_RESET;
    endproperty
    a_gauge_reset: assert property (p_gauge_reset) else $error("gauge not zero");

    // Letting go of the bit before the count is up never starts the device reset.
    property p_srst_short;
        @(posedge sys_clk) disable iff (rst)
        ce && srst_q == lgcb_pkg::SR_COUNT && !gcr0_q[`LGCB_SRST_BIT] |=> !dev_reset_q;
    endproperty
    a_srst_short: assert property (p_srst_short) else $error("short hold took effect");

    // Clearing the bit ends the device reset on the next edge and frees the line logic.
    property p_srst_release;
        @(posedge sys_clk) disable iff (rst)
        ce && dev_reset_q && !gcr0_q[`LGCB_SRST_BIT] |=> !dev_reset_q && !link_rst_req_q;
    endproperty
    a_srst_release: assert property (p_srst_release) else $error("reset not released");

    // The device reset leaves both control registers alone while the host is quiet.
    property p_regs_keep;
        @(posedge sys_clk) disable iff (rst)
        dev_reset_q && !host_wr |=> $stable(gcr0_q) && $stable(gcr1_q);
    endproperty
    a_regs_keep: assert property (p_regs_keep) else $error("registers lost in reset");

    // The gauge pins always mirror bits 5 to 4 of the second register.
    property p_gauge_follow;
        @(posedge sys_clk) disable iff (rst)
        gauge_select_q == gcr1_q[`LGCB_GAUGE_HI:`LGCB_GAUGE_LO];
    endproperty
    a_gauge_follow: assert property (p_gauge_follow) else $error("gauge pins stale");

    // No sticky state: with nothing pending and enabled the pin is low next cycle.
    property p_irq_drop;
        @(posedge sys_clk) disable iff (rst)
        ce && !src_any |=> !irq_q;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq without pending source");

    // Main scenarios.
    c_irq_rise: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq_q));
    c_srst_done: cover property (@(posedge sys_clk) disable iff (rst) $rose(dev_reset_q));
    c_gauge_22: cover property (@(posedge sys_clk) disable iff (rst) gauge_select_q == 2'h1);
    c_srst_refused: cover property (@(posedge sys_clk) disable iff (rst)
        srst_q == lgcb_pkg::SR_COUNT && !gcr0_q[`LGCB_SRST_BIT]);

endmodule

// ==== tb/lgcb_framer_model.sv ====
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Framer-side transmit logic facing the line interface.
// Each symbol is valid only around the edge the device is told to sample on.
// The opposite edge sees the inverted symbol, so a wrong edge or polarity shows up.
module lgcb_framer_model #(
    parameter int QTR_NS = 12
) (
    input wire logic line_clk,
    input wire logic sample_rise,
    input wire logic active_low,
    input wire lgcb_pkg::lgcb_rail_t symbol,
    output lgcb_pkg::lgcb_rail_t tx_pins
);
    // Symbol as it appears on the pins under the chosen polarity.
    lgcb_pkg::lgcb_rail_t pin_sym;

    assign pin_sym = symbol ^ {2{active_low}};

    // The pins start low until the line clock runs.
    initial tx_pins = 2'b00;

    // A quarter period after a falling edge, set up the value for the next rising edge.
    always @(negedge line_clk) begin
        #(QTR_NS);
        tx_pins = sample_rise ? pin_sym : ~pin_sym;
    end

    // A quarter period after a rising edge, set up the value for the next falling edge.
    always @(posedge line_clk) begin
        #(QTR_NS);
        tx_pins = sample_rise ? ~pin_sym : pin_sym;
    end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "lgcb_defines.svh"

`define TB_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_top;
    // Short soft reset hold so the run stays brief; every expectation uses it.
    localparam int unsigned SR_CYC = 8;
    localparam logic [15:0] A0 = `LGCB_GCR0_ADDR;
    localparam logic [15:0] A1 = `LGCB_GCR1_ADDR;

    logic sys_clk = 1'b0;
    logic line_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [15:0] host_addr = 16'h0000;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [7:0] host_wdata = 8'h00;
    logic [7:0] host_rdata_q;
    logic [7:0] src_status = 8'h00;
    logic [7:0] src_enable = 8'h00;
    logic irq_q;
    logic dev_reset_q;
    logic [1:0] gauge_select_q;
    lgcb_pkg::lgcb_rail_t tx_data_q;
    lgcb_pkg::lgcb_rail_t rx_data_in = 2'b00;
    lgcb_pkg::lgcb_rail_t tx_dual_rail_data;
    lgcb_pkg::lgcb_rail_t rx_dual_rail_data;
    lgcb_pkg::lgcb_rail_t sym = 2'b00;
    logic tx_rise = 1'b0;
    logic pol = 1'b0;
    logic rx_chg_hi = 1'b0;
    int bad_count = 0;
    int checks_done = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clocks. The line clock starts at an odd offset so it has no phase tie to sys_clk.
    always #12.5 sys_clk = ~sys_clk;

    initial begin
        #7;
        forever #24 line_clk = ~line_clk;
    end

    // Remember the line clock level whenever the receive pins move.
    always @(rx_dual_rail_data) rx_chg_hi = line_clk;

    lgcb_top #(.NSRC(8), .SRST_CYC(SR_CYC)) uut (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata_q(host_rdata_q), .src_status(src_status), .src_enable(src_enable),
        .irq_q(irq_q), .dev_reset_q(dev_reset_q), .gauge_select_q(gauge_select_q),
        .tx_data_q(tx_data_q), .rx_data_in(rx_data_in), .tx_line_clock(line_clk),
        .tx_dual_rail_data(tx_dual_rail_data), .rx_dual_rail_data(rx_dual_rail_data)
    );

    lgcb_framer_model far (
        .line_clk(line_clk), .sample_rise(tx_rise), .active_low(pol),
        .symbol(sym), .tx_pins(tx_dual_rail_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus cycles. Inputs move 2 ns after a rising edge and are held across the taking edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cyc(1);
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        cyc(1);
        host_wr = 1'b0;
    endtask

    // Read data is registered, so it is settled right after the taking edge.
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        cyc(1);
        host_addr = a;
        host_rd = 1'b1;
        cyc(1);
        host_rd = 1'b0;
        `TB_CHK(host_rdata_q, exp)
    endtask

    task automatic end_sim;
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, gauge codes, unmapped place, reserved bit and a frozen write.
    task automatic t_regs;
        rd_chk(A0, 8'h00);
        rd_chk(A1, 8'h00);
        `TB_CHK(gauge_select_q, 2'b00)
        wr(16'h0fe4, 8'hff);
        rd_chk(16'h0fe4, 8'h00);
        rd_chk(A0, 8'h00);
        for (int g = 0; g < 4; g++) begin
            wr(A1, {2'b00, g[1:0], 4'h5});
            rd_chk(A1, {2'b00, g[1:0], 4'h5});
            `TB_CHK(gauge_select_q, g[1:0])
        end
        ce = 1'b0;
        wr(A1, 8'h00);
        ce = 1'b1;
        rd_chk(A1, 8'h35);
        wr(A0, 8'hc4);
        rd_chk(A0, 8'hc0);
        wr(A0, 8'h00);
    endtask

    // Interrupt gating per source, global gate off and on.
    task automatic t_irq;
        src_enable = 8'hff;
        src_status = 8'hff;
        cyc(3);
        `TB_CHK(irq_q, 1'b0)
        wr(A0, 8'h02);
        for (int i = 0; i < 8; i++) begin
            src_status = 8'h01 << i;
            src_enable = ~(8'h01 << i);
            cyc(2);
            `TB_CHK(irq_q, 1'b0)
            src_enable = 8'h01 << i;
            cyc(2);
            `TB_CHK(irq_q, 1'b1)
            src_status = 8'h00;
            cyc(2);
            `TB_CHK(irq_q, 1'b0)
        end
        src_status = 8'h80;
        cyc(2);
        `TB_CHK(irq_q, 1'b1)
        wr(A0, 8'h00);
        cyc(1);
        `TB_CHK(irq_q, 1'b0)
    endtask

    // Soft reset: a short hold is refused, a full hold resets circuits but not registers.
    task automatic t_srst;
        sym = 2'b10;
        src_status = 8'h01;
        src_enable = 8'h01;
        wr(A1, 8'h20);
        wr(A0, 8'h03);
        cyc(4);
        wr(A0, 8'h02);
        cyc(SR_CYC + 6);
        `TB_CHK(dev_reset_q, 1'b0)
        `TB_CHK(irq_q, 1'b1)
        `TB_CHK(tx_data_q, 2'b10)
        wr(A0, 8'h03);
        cyc(SR_CYC + 1);
        `TB_CHK(dev_reset_q, 1'b0)
        cyc(1);
        `TB_CHK(dev_reset_q, 1'b1)
        cyc(6);
        `TB_CHK(irq_q, 1'b0)
        `TB_CHK(tx_data_q, 2'b00)
        rd_chk(A0, 8'h03);
        rd_chk(A1, 8'h20);
        `TB_CHK(gauge_select_q, 2'b10)
        wr(A0, 8'h02);
        cyc(2);
        `TB_CHK(dev_reset_q, 1'b0)
        `TB_CHK(irq_q, 1'b1)
        src_status = 8'h00;
        wr(A0, 8'h00);
    endtask

    // Every mix of transmit edge, receive edge and polarity.
    task automatic t_link;
        logic rxe;
        for (int k = 0; k < 8; k++) begin
            rxe = k[2];
            tx_rise = k[1];
            pol = k[0];
            sym = k[0] ? 2'b01 : 2'b10;
            wr(A0, {2'b00, rxe, tx_rise, pol, 3'b000});
            rx_data_in = sym;
            cyc(20);
            rx_data_in = ~sym;
            cyc(20);
            `TB_CHK(tx_data_q, sym)
            `TB_CHK(rx_dual_rail_data, (~sym) ^ {2{pol}})
            `TB_CHK(rx_chg_hi, ~rxe)
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; the line logic needs several line clocks after reset.
    initial begin
        repeat (10) @(posedge sys_clk);
        #2;
        rst = 1'b0;
        cyc(20);
        t_regs();
        t_irq();
        t_srst();
        t_link();
        end_sim();
    end

    // Watchdog: the whole run needs well under 2000 sys_clk cycles.
    initial begin
        #300000;
        bad_count++;
        end_sim();
    end
endmodule
